// File: src/ias_pkg.sv
package ias_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_OPA = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_RES_LO = 8'h14;
  localparam logic [7:0] OFF_RES_HI = 8'h18;
  localparam logic [7:0] OFF_PSW = 8'h1C;
  localparam logic [7:0] OFF_TRAP = 8'h20;
  localparam int WORD_STRIDE = 4;
  localparam int SRC_REGS = 4;
  // command word fields
  localparam int CMD_SAT = 5;
  localparam int CMD_UNS = 6;
  localparam int CMD_SZ = 7;
  localparam int CMD_SH1 = 9;
  localparam int CMD_PAIR = 10;
  localparam int CMD_HSEL = 11;
  localparam int CMD_IMM = 16;
  localparam logic [1:0] SZ_WORD = 2'h0;
  localparam logic [1:0] SZ_HALF = 2'h1;
  // program_status_word bits
  localparam int PSW_W = 5;
  localparam int PSW_C = 4;
  localparam int PSW_V = 3;
  localparam int PSW_SV = 2;
  localparam int PSW_AV = 1;
  localparam int PSW_SAV = 0;
  localparam logic [PSW_W-1:0] PSW_RST = 5'h00;
  // saturation bounds and rounding constants
  localparam logic [31:0] S_MAX = 32'h7FFFFFFF;
  localparam logic [31:0] S_MIN = 32'h80000000;
  localparam logic [31:0] U_MAX = 32'hFFFFFFFF;
  localparam logic [63:0] S_MAX64 = 64'h7FFFFFFFFFFFFFFF;
  localparam logic [63:0] S_MIN64 = 64'h8000000000000000;
  localparam logic [65:0] RND_Q = 66'h000000080000000;
  localparam logic [32:0] RND_H = 33'h000008000;
  // operation codes
  localparam logic [4:0] sum_op = 5'h00;
  localparam logic [4:0] difference_op = 5'h01;
  localparam logic [4:0] extended_sum_op = 5'h02;
  localparam logic [4:0] sum_with_carry_op = 5'h03;
  localparam logic [4:0] extended_difference_op = 5'h04;
  localparam logic [4:0] difference_with_borrow_op = 5'h05;
  localparam logic [4:0] immediate_sum_op = 5'h06;
  localparam logic [4:0] immediate_high_sum_op = 5'h07;
  localparam logic [4:0] reverse_subtract_op = 5'h08;
  localparam logic [4:0] sign_extend_load_op = 5'h09;
  localparam logic [4:0] zero_extend_load_op = 5'h0A;
  localparam logic [4:0] high_word_load_op = 5'h0B;
  localparam logic [4:0] integer_product_op = 5'h0C;
  localparam logic [4:0] product_accumulate_op = 5'h0D;
  localparam logic [4:0] product_deduct_op = 5'h0E;
  localparam logic [4:0] fraction_product_op = 5'h0F;
  localparam logic [4:0] rounded_fraction_product_op = 5'h10;
  localparam logic [4:0] packed_exact_product_op = 5'h11;
  localparam logic [4:0] packed_rounded_product_op = 5'h12;
  localparam logic [4:0] packed_multiprecision_product_op = 5'h13;
  localparam logic [4:0] arith_shift_op = 5'h14;
  localparam logic [4:0] clear_overflow_bits_op = 5'h15;
  localparam logic [4:0] trap_if_overflow_op = 5'h16;
  localparam logic [4:0] trap_if_sticky_overflow_op = 5'h17;
endpackage

// File: src/ias_unit.sv
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// Summary of operation
// RL1 - Carry flag set by add/subtract carry out and by arithmetic shift.
// RL2 - Overflow flag set when signed result exceeds destination range.
// RL3 - Sticky overflow set with overflow, held until clear-overflow operation.
// RL4 - Advance overflow updated with overflow: xor of two result MSBs.
// RL5 - Sticky advance overflow set with advance overflow, held until clear.
// RL6 - Packed operations OR overflow conditions across all lanes.
// RL7 - Multiply-accumulate signed_saturating_sum_op product to accumulator; flags checked after.
// RL8 - Unsigned overflow is carry for add, missing carry for subtract.
// RL9 - Software reads and writes flags; clear operation resets overflow bits.
// RL10 - Trap on overflow op if V set; on sticky op if SV set.
// RL11 - Signed saturation clamps to 2^(n-1)-1 or -2^(n-1).
// RL12 - Unsigned saturation clamps to zero or 2^n-1.
// RL13 - Constant loads sign-extend, zero-extend, or place in upper half.
// RL14 - Extended add sets carry; add-with-carry uses and updates it; no saturation.
// RL15 - Immediate add uses sign-extended constant; high form shifts it by 16.
// RL16 - Reverse subtract computes constant minus register.
// RL17 - Integer product gives 32 bits, or 64 bits into a register pair.
// RL18 - Narrow fractional destination takes upper product bits.
// RL19 - Fractional product shifted left by zero or one before storing.
// RL20 - Packed exact product stores two 32-bit products in a pair.
// RL21 - Packed rounded product rounds, packs two 16-bit results.
// RL22 - Packed multiprecision product sums both products into a pair.
// RL23 - Non-saturating results wrap, still updating carry and overflow.
module ias_unit
  import ias_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // trap request to the core
  output logic trap_req
);
  if (ADDR_W < 6 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must be 6 to 32");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
    return a == ADDR_W'(off);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // one lane of add/subtract, aligned to bit 31 so carry and sign sit at the top
  function automatic logic [34:0] lane_add(input logic [31:0] a, input logic [31:0] b, input logic [5:0] w,
                                           input logic sub, input logic cin, input logic sat, input logic uns);
    logic [31:0] x;
    logic [31:0] y;
    logic [31:0] r;
    logic [32:0] s;
    logic [5:0] gap;
    logic v;
    logic uo;
    gap = 6'd32 - w;
    x = a << gap;
    y = b << gap;
    s = {1'b0, x} + {1'b0, sub ? ~y : y} + ({32'h0, cin} << gap);
    v = (x[31] == (y[31] ^ sub)) && (s[31] != x[31]); // RL2
    uo = sub ? ~s[32] : s[32]; // RL8
    r = s[31:0]; // RL23
    if (sat && uns && uo) begin
      r = sub ? 32'h0 : U_MAX; // RL12
    end else if (sat && !uns && v) begin
      r = x[31] ? S_MIN : S_MAX; // RL11
    end
    return {v, r[31] ^ r[30], s[32], r >> gap}; // RL4
  endfunction

  logic [31:0] src [SRC_REGS];
  logic [31:0] cmd;
  logic [31:0] res_lo;
  logic [31:0] res_hi;
  logic [PSW_W-1:0] program_status_word;
  logic go;
  logic req;
  logic wr;
  logic [31:0] rd_val;
  logic [31:0] opa;
  logic [31:0] opb;
  logic [4:0] op;
  logic [15:0] imm;
  logic [31:0] simm;
  logic [1:0] hsel;
  logic pair;
  logic sh1;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign opa = src[0];
  assign opb = src[1];
  assign op = cmd[4:0];
  assign imm = cmd[CMD_IMM +: 16];
  assign simm = {{16{imm[15]}}, imm};
  assign hsel = cmd[CMD_HSEL +: 2];
  assign pair = cmd[CMD_PAIR];
  assign sh1 = cmd[CMD_SH1];

  // bus answers one cycle after the request, unmapped reads give zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= (req && !wb_we_i) ? rd_val : 32'h0;
    end
  end

  always_comb begin
    rd_val = 32'h0;
    for (int g = 0; g < SRC_REGS; g++) begin
      if (hit(wb_adr_i, OFF_OPA + 8'(WORD_STRIDE * g))) begin
        rd_val = src[g];
      end
    end
    if (hit(wb_adr_i, OFF_CMD)) rd_val = cmd;
    if (hit(wb_adr_i, OFF_RES_LO)) rd_val = res_lo;
    if (hit(wb_adr_i, OFF_RES_HI)) rd_val = res_hi;
    if (hit(wb_adr_i, OFF_PSW)) rd_val = 32'(program_status_word); // RL9
    if (hit(wb_adr_i, OFF_TRAP)) rd_val = 32'(trap_req);
  end

  for (genvar g = 0; g < SRC_REGS; g++) begin : g_src
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        src[g] <= 32'h0;
      end else if (wr && hit(wb_adr_i, OFF_OPA + 8'(WORD_STRIDE * g))) begin
        src[g] <= merge(src[g], wb_dat_i, wb_sel_i);
      end
    end
  end

  // a command write launches one operation in the following cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd <= 32'h0;
      go <= 1'b0;
    end else begin
      go <= wr && hit(wb_adr_i, OFF_CMD);
      if (wr && hit(wb_adr_i, OFF_CMD)) begin
        cmd <= merge(cmd, wb_dat_i, wb_sel_i);
      end
    end
  end

  // multiplier operands and wide result
  logic [31:0] ma;
  logic [31:0] mb;
  logic signed [65:0] pw;
  logic signed [65:0] acc66;
  logic signed [65:0] wide;
  logic mv;
  logic [63:0] mr;
  logic [31:0] hp [2];
  logic [31:0] hr;
  logic [33:0] hsum;
  logic hv;
  logic hav;

  always_comb begin
    ma = opa;
    mb = opb;
    if (op == fraction_product_op || op == rounded_fraction_product_op) begin
      case (hsel)
        2'h1: begin ma = {opa[31:16], 16'h0}; mb = {opb[31:16], 16'h0}; end
        2'h2: begin ma = {opa[15:0], 16'h0}; mb = {opb[15:0], 16'h0}; end
        2'h3: ma = {opa[31:16], 16'h0};
        default: ;
      endcase
    end
    pw = 66'($signed(ma) * $signed(mb));
    acc66 = pair ? 66'($signed({src[3], src[2]})) : 66'($signed(src[2]));
    case (op)
      product_accumulate_op: wide = pw + acc66; // RL7
      product_deduct_op: wide = pw - acc66; // RL7
      fraction_product_op, rounded_fraction_product_op: begin
        wide = sh1 ? pw <<< 1 : pw; // RL19
        if (!pair) begin
          if (op == rounded_fraction_product_op) wide = wide + RND_Q;
          wide = wide >>> 32; // RL18
        end
      end
      default: wide = pw; // RL17
    endcase
    mv = pair ? (wide[65:64] != {2{wide[63]}}) : (wide[65:32] != {34{wide[31]}});
    mr = wide[63:0];
    if (mv && cmd[CMD_SAT]) begin
      mr = pair ? (wide[65] ? S_MIN64 : S_MAX64) : {32'h0, wide[65] ? S_MIN : S_MAX}; // RL11
    end
  end

  // two 16x16 lanes for the packed products
  always_comb begin
    logic [15:0] bh;
    logic signed [31:0] p;
    logic [32:0] ps;
    logic [32:0] rr;
    bh = 16'h0;
    p = 32'h0;
    ps = 33'h0;
    rr = 33'h0;
    hv = 1'b0;
    hav = 1'b0;
    hr = 32'h0;
    hsum = 34'h0;
    for (int i = 0; i < 2; i++) begin
      bh = ((i == 1) ? (hsel == 2'h0 || hsel == 2'h3) : (hsel == 2'h1 || hsel == 2'h3)) ? opb[31:16] : opb[15:0];
      p = $signed(opa[i*16 +: 16]) * $signed(bh);
      ps = sh1 ? {p[31], p} << 1 : {p[31], p};
      rr = ps + RND_H; // RL21
      hp[i] = ps[31:0]; // RL20
      hr[i*16 +: 16] = rr[31:16];
      hv = hv | (ps[32] != ps[31]) | (rr[32] != rr[31]); // RL6
      hav = hav | (ps[31] ^ ps[30]); // RL6
      hsum = hsum + {ps[32], ps}; // RL22
    end
  end

  // execution
  logic [31:0] la;
  logic [31:0] lb;
  logic lsub;
  logic lcin;
  logic lsat;
  logic [1:0] lsz;
  logic use_lane;
  logic [31:0] next_lo;
  logic [31:0] next_hi;
  logic next_v;
  logic next_av;
  logic next_c;
  logic upd_v;
  logic upd_c;

  always_comb begin
    logic [34:0] t;
    logic [32:0] sft;
    int lw;
    lw = 32;
    t = 35'h0;
    sft = 33'h0;
    la = opa;
    lb = opb;
    lsub = 1'b0;
    lcin = 1'b0;
    lsat = cmd[CMD_SAT];
    lsz = cmd[CMD_SZ +: 2];
    use_lane = 1'b0;
    next_lo = res_lo;
    next_hi = res_hi;
    next_v = 1'b0;
    next_av = 1'b0;
    next_c = program_status_word[PSW_C];
    upd_v = 1'b0;
    upd_c = 1'b0;
    case (op)
      sum_op: use_lane = 1'b1;
      difference_op: begin use_lane = 1'b1; lsub = 1'b1; lcin = 1'b1; end
      extended_sum_op, sum_with_carry_op, extended_difference_op, difference_with_borrow_op: begin
        use_lane = 1'b1;
        lsat = 1'b0; // RL14
        lsz = SZ_WORD;
        lsub = op == extended_difference_op || op == difference_with_borrow_op;
        lcin = (op == extended_sum_op) ? 1'b0 : (op == extended_difference_op) ? 1'b1 : program_status_word[PSW_C]; // RL14
      end
      immediate_sum_op: begin use_lane = 1'b1; lb = simm; lsz = SZ_WORD; end // RL15
      immediate_high_sum_op: begin use_lane = 1'b1; lb = {imm, 16'h0}; lsz = SZ_WORD; end // RL15
      reverse_subtract_op: begin use_lane = 1'b1; la = simm; lb = opa; lsub = 1'b1; lcin = 1'b1; end // RL16
      sign_extend_load_op: next_lo = simm; // RL13
      zero_extend_load_op: next_lo = {16'h0, imm}; // RL13
      high_word_load_op: next_lo = {imm, 16'h0}; // RL13
      integer_product_op, product_accumulate_op, product_deduct_op, fraction_product_op,
      rounded_fraction_product_op: begin
        next_lo = mr[31:0];
        if (pair) next_hi = mr[63:32];
        next_v = mv;
        next_av = pair ? mr[63] ^ mr[62] : mr[31] ^ mr[30];
        upd_v = 1'b1;
      end
      packed_exact_product_op: begin next_lo = hp[0]; next_hi = hp[1]; next_v = hv; next_av = hav; upd_v = 1'b1; end
      packed_rounded_product_op: begin next_lo = hr; next_v = hv; next_av = hav; upd_v = 1'b1; end
      packed_multiprecision_product_op: begin
        {next_hi, next_lo} = 64'($signed(hsum)) << 16;
        next_av = hsum[33] ^ hsum[32];
        upd_v = 1'b1;
      end
      arith_shift_op: begin
        if (!imm[5]) begin
          sft = {1'b0, opa} << imm[4:0];
          next_lo = sft[31:0];
          next_c = sft[32];
          next_v = ($signed(sft[31:0]) >>> imm[4:0]) != $signed(opa);
        end else begin
          sft = 33'($signed({opa, 1'b0}) >>> 5'(-imm[4:0]));
          next_lo = sft[32:1];
          next_c = sft[0];
        end
        next_av = next_lo[31] ^ next_lo[30];
        upd_v = 1'b1;
        upd_c = 1'b1; // RL1
      end
      default: ;
    endcase
    if (use_lane) begin
      lw = (lsz == SZ_WORD || lsz == 2'h3) ? 32 : (lsz == SZ_HALF) ? 16 : 8;
      next_lo = 32'h0;
      for (int i = 0; i < 4; i++) begin
        if (i * lw < 32) begin
          t = lane_add(la >> (i * lw), lb >> (i * lw), 6'(lw), lsub, lcin, lsat, cmd[CMD_UNS]);
          next_lo = next_lo | (t[31:0] << (i * lw));
          next_v = next_v | t[34]; // RL6
          next_av = next_av | t[33]; // RL6
          next_c = t[32]; // RL1
        end
      end
      upd_v = 1'b1;
      upd_c = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      res_lo <= 32'h0;
      res_hi <= 32'h0;
    end else if (go) begin
      res_lo <= next_lo;
      res_hi <= next_hi;
    end
  end

  // bus write and execution never share a cycle, so no priority is lost here
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      program_status_word <= PSW_RST;
    end else if (wr && hit(wb_adr_i, OFF_PSW) && wb_sel_i[0]) begin
      program_status_word <= wb_dat_i[PSW_W-1:0]; // RL9
    end else if (go && op == clear_overflow_bits_op) begin
      program_status_word[PSW_V] <= 1'b0; // RL9
      program_status_word[PSW_SV] <= 1'b0; // RL3
      program_status_word[PSW_AV] <= 1'b0;
      program_status_word[PSW_SAV] <= 1'b0; // RL5
    end else if (go) begin
      if (upd_v) begin
        program_status_word[PSW_V] <= next_v; // RL2
        program_status_word[PSW_SV] <= program_status_word[PSW_SV] | next_v; // RL3
        program_status_word[PSW_AV] <= next_av; // RL4
        program_status_word[PSW_SAV] <= program_status_word[PSW_SAV] | next_av; // RL5
      end
      if (upd_c) program_status_word[PSW_C] <= next_c; // RL1
    end
  end

  // trap flag: write one to clear, a new trap wins over the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trap_req <= 1'b0;
    end else if (go && ((op == trap_if_overflow_op && program_status_word[PSW_V]) ||
                        (op == trap_if_sticky_overflow_op && program_status_word[PSW_SV]))) begin
      trap_req <= 1'b1; // RL10
    end else if (wr && hit(wb_adr_i, OFF_TRAP) && wb_sel_i[0] && wb_dat_i[0]) begin
      trap_req <= 1'b0;
    end
  end

  // assertion helpers
  logic [32:0] sum33;
  logic add_sv;
  logic [31:0] reverse_subtract_op_ref;
  assign sum33 = {1'b0, opa} + {1'b0, opb};
  assign add_sv = (opa[31] == opb[31]) && (sum33[31] != opa[31]);
  assign reverse_subtract_op_ref = simm - opa;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_sv_set;
    go && upd_v && next_v && op != clear_overflow_bits_op |=> program_status_word[PSW_SV] && program_status_word[PSW_V];
  endproperty
  a_sv_set: assert property (p_sv_set) else $error("sticky overflow not set"); // RL3
  property p_sv_hold;
    program_status_word[PSW_SV] && !(go && op == clear_overflow_bits_op) && !(wr && hit(wb_adr_i, OFF_PSW)) |=> program_status_word[PSW_SV];
  endproperty
  a_sv_hold: assert property (p_sv_hold) else $error("sticky overflow lost"); // RL3
  property p_sav_set;
    go && upd_v && next_av |=> program_status_word[PSW_SAV] && program_status_word[PSW_AV];
  endproperty
  a_sav_set: assert property (p_sav_set) else $error("sticky advance overflow not set"); // RL5
  property p_trap_if_overflow_op;
    go && op == trap_if_overflow_op && program_status_word[PSW_V] |=> trap_req;
  endproperty
  a_trap_if_overflow_op: assert property (p_trap_if_overflow_op) else $error("overflow trap missing"); // RL10
  property p_reverse_subtract_op;
    go && op == reverse_subtract_op && cmd[CMD_SZ +: 2] == SZ_WORD && !cmd[CMD_SAT] |=> res_lo == $past(reverse_subtract_op_ref);
  endproperty
  a_reverse_subtract_op: assert property (p_reverse_subtract_op) else $error("reverse subtract wrong"); // RL16
  property p_high_word_load_op;
    go && op == high_word_load_op |=> res_lo == {$past(imm), 16'h0};
  endproperty
  a_high_word_load_op: assert property (p_high_word_load_op) else $error("high word load wrong"); // RL13
  property p_extended_sum_op_c;
    go && op == extended_sum_op |=> program_status_word[PSW_C] == $past(sum33[32]) ##1 program_status_word[PSW_C] == $past(program_status_word[PSW_C]);
  endproperty
  a_extended_sum_op_c: assert property (p_extended_sum_op_c) else $error("extended sum carry wrong"); // RL14
  property p_usat;
    go && op == sum_op && cmd[CMD_SAT] && cmd[CMD_UNS] && cmd[CMD_SZ +: 2] == SZ_WORD && sum33[32]
      |=> res_lo == U_MAX;
  endproperty
  a_usat: assert property (p_usat) else $error("unsigned saturation wrong"); // RL12
  property p_ovf;
    go && op == sum_op && cmd[CMD_SZ +: 2] == SZ_WORD |=> program_status_word[PSW_V] == $past(add_sv);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag wrong"); // RL2
endmodule

// File: dv/ias_core_model.sv
`timescale 1ns/1ns
module ias_core_model (
  // clock
  input wire logic clk,
  // bus master side
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [7:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dout,
  // slave answer
  input wire logic [31:0] din,
  input wire logic ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dout = 32'h00000000;
  end

  // request held until ack is seen at an edge; released at that same edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dout <= d;
    // no limit here: only the bench watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = din;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    // released lines show garbage, not the last value
    adr <= ~a;
    dout <= ~d;
  endtask
endmodule

// File: dv/ias_unit_tb_top.sv
`timescale 1ns/1ns
module ias_unit_tb_top
  import ias_pkg::*;
;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  wire cyc, stb, we, ack, trap_req;
  wire [7:0] adr;
  wire [3:0] sel;
  wire [31:0] dout, din;
  int bad_count = 0;
  int num_checks = 0;
  logic [31:0] q, a, b;

  always #10 clk = ~clk;

  ias_unit ias_unit_i (.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dout), .wb_dat_o(din), .wb_ack_o(ack), .trap_req(trap_req));
  ias_core_model ias_core_model_i (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dout(dout), .din(din), .ack(ack));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    logic [31:0] z;
    ias_core_model_i.xfer(1'b1, ad, d, z);
  endtask

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    ias_core_model_i.xfer(1'b0, ad, 32'h00000000, d);
  endtask

  // md: bit0 sat, bit1 unsigned, bits3:2 size, bit4 shift, bit5 pair, bits7:6 half select
  function automatic logic [31:0] cm(input logic [4:0] op, input logic [15:0] imm, input logic [7:0] md);
    return {imm, 3'h0, md, op};
  endfunction

  task automatic ex(input logic [31:0] x, input logic [31:0] y, input logic [31:0] c);
    wr(OFF_OPA, x);
    wr(8'h04, y);
    wr(OFF_CMD, c);
  endtask

  task automatic t1(input logic [31:0] x, input logic [31:0] y, input logic [31:0] c, input logic [31:0] lo);
    logic [31:0] r;
    ex(x, y, c);
    rd(OFF_RES_LO, r);
    chk(r, lo);
  endtask

  task automatic t2(input logic [31:0] x, input logic [31:0] y, input logic [31:0] c, input logic [63:0] e);
    logic [31:0] r;
    t1(x, y, c, e[31:0]);
    rd(OFF_RES_HI, r);
    chk(r, e[63:32]);
  endtask

  // trap flag moves on the edge that ends the command write, so look mid-cycle
  task automatic trap_is(input logic e);
    @(negedge clk);
    chk({31'h0, trap_req}, {31'h0, e});
  endtask

  // flags of a fresh add or subtract with the status word cleared beforehand
  function automatic logic [31:0] fl(input logic [31:0] x, input logic [31:0] y, input logic s);
    logic [32:0] t;
    logic v;
    logic av;
    t = s ? {1'b0, x} + {1'b0, ~y} + 33'h1 : {1'b0, x} + {1'b0, y};
    v = (x[31] == (y[31] ^ s)) && (t[31] != x[31]);
    av = t[31] ^ t[30];
    return {27'h0, t[32], v, v, av, av};
  endfunction

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(20 * 6000);
    bad_count++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    void'($urandom(44));
    rd(OFF_PSW, q);
    chk(q, 32'h0);
    rd(8'h24, q);
    chk(q, 32'h0);
    done("reset");
    for (int i = 0; i < 16; i++) begin
      a = $urandom;
      b = (i == 0) ? 32'h00000001 : $urandom;
      if (i == 0) a = 32'h7FFFFFFF;
      if (i == 1) b = a;
      wr(OFF_PSW, 32'h0);
      t1(a, b, cm({4'h0, i[0]}, 16'h0, 8'h00), i[0] ? a - b : a + b);
      rd(OFF_PSW, q);
      chk(q, fl(a, b, i[0]));
    end
    done("random");
    t1(32'h7FFFFFFF, 32'h00000001, cm(5'h00, 16'h0, 8'h01), 32'h7FFFFFFF);
    t1(32'h80000000, 32'hFFFFFFFF, cm(5'h00, 16'h0, 8'h01), 32'h80000000);
    t1(32'h807F0000, 32'hFF010000, cm(5'h00, 16'h0, 8'h09), 32'h807F0000);
    t1(32'hFFFFFFFF, 32'h00000002, cm(5'h00, 16'h0, 8'h03), 32'hFFFFFFFF);
    t1(32'h00000001, 32'h00000002, cm(5'h01, 16'h0, 8'h03), 32'h00000000);
    t1(32'hFF000000, 32'h01000000, cm(5'h00, 16'h0, 8'h0B), 32'hFF000000);
    t1(32'hFFFF0000, 32'h00010000, cm(5'h00, 16'h0, 8'h07), 32'hFFFF0000);
    wr(OFF_PSW, 32'h0);
    t1(32'h7FFF0001, 32'h00010001, cm(5'h00, 16'h0, 8'h05), 32'h7FFF0002);
    rd(OFF_PSW, q);
    chk(q & 32'h8, 32'h8);
    done("saturation");
    t1(32'h0000000A, 32'h0, cm(5'h06, 16'hFFFF, 8'h00), 32'h00000009);
    t1(32'h00000001, 32'h0, cm(5'h07, 16'h1234, 8'h00), 32'h12340001);
    t1(32'h00000005, 32'h0, cm(5'h08, 16'h0000, 8'h00), 32'hFFFFFFFB);
    t1(32'h00000003, 32'h0, cm(5'h08, 16'h0010, 8'h00), 32'h0000000D);
    wr(OFF_PSW, 32'h0);
    t1(32'h0, 32'h0, cm(5'h09, 16'h8000, 8'h00), 32'hFFFF8000);
    t1(32'h0, 32'h0, cm(5'h0A, 16'h8000, 8'h00), 32'h00008000);
    t1(32'h0, 32'h0, cm(5'h0B, 16'h8000, 8'h00), 32'h80000000);
    rd(OFF_PSW, q);
    chk(q, 32'h0);
    done("constants");
    t1(32'hFFFFFFFF, 32'h1, cm(5'h02, 16'h0, 8'h00), 32'h0);
    rd(OFF_PSW, q);
    chk(q & 32'h10, 32'h10);
    t1(32'h0, 32'h0, cm(5'h03, 16'h0, 8'h00), 32'h1);
    rd(OFF_PSW, q);
    chk(q & 32'h10, 32'h0);
    t1(32'h0, 32'h1, cm(5'h04, 16'h0, 8'h00), 32'hFFFFFFFF);
    t1(32'h5, 32'h1, cm(5'h05, 16'h0, 8'h00), 32'h3);
    rd(OFF_PSW, q);
    chk(q & 32'h10, 32'h10);
    done("carry_chain");
    t2(32'h00010001, 32'h00010000, cm(5'h0C, 16'h0, 8'h20), 64'h0000000100010000);
    t1(32'h00010001, 32'h00010000, cm(5'h0C, 16'h0, 8'h00), 32'h00010000);
    t1(32'h40000000, 32'h40000000, cm(5'h0F, 16'h0, 8'h10), 32'h20000000);
    t1(32'h40000000, 32'h40000000, cm(5'h0F, 16'h0, 8'h00), 32'h10000000);
    t1(32'h40000000, 32'h00000001, cm(5'h10, 16'h0, 8'h10), 32'h00000001);
    t2(32'h00020003, 32'h00040005, cm(5'h11, 16'h0, 8'h20), 64'h000000080000000F);
    t1(32'h40000001, 32'h40004000, cm(5'h12, 16'h0, 8'h10), 32'h20000001);
    t2(32'h00010002, 32'h00030004, cm(5'h13, 16'h0, 8'h20), 64'h00000000000B0000);
    wr(8'h08, 32'h7FFFFFFF);
    wr(OFF_PSW, 32'h0);
    t1(32'h1, 32'h1, cm(5'h0D, 16'h0, 8'h00), 32'h80000000);
    rd(OFF_PSW, q);
    chk(q & 32'hF, 32'hF);
    t1(32'h1, 32'h1, cm(5'h0E, 16'h0, 8'h00), 32'h80000002);
    done("products");
    wr(OFF_PSW, 32'h0);
    t1(32'h80000001, 32'h0, cm(5'h14, 16'h0001, 8'h00), 32'h00000002);
    rd(OFF_PSW, q);
    chk(q, 32'h1C);
    t1(32'h80000003, 32'h0, cm(5'h14, 16'h003F, 8'h00), 32'hC0000001);
    rd(OFF_PSW, q);
    chk(q & 32'h10, 32'h10);
    done("shift");
    wr(OFF_PSW, 32'h0);
    ex(32'h7FFFFFFF, 32'h1, cm(5'h00, 16'h0, 8'h00));
    ex(32'h1, 32'h1, cm(5'h00, 16'h0, 8'h00));
    rd(OFF_PSW, q);
    chk(q, 32'h05);
    wr(OFF_PSW, 32'h1F);
    rd(OFF_PSW, q);
    chk(q, 32'h1F);
    wr(OFF_CMD, cm(5'h15, 16'h0, 8'h00));
    rd(OFF_PSW, q);
    chk(q, 32'h10);
    done("sticky");
    wr(OFF_PSW, 32'h0);
    wr(OFF_CMD, cm(5'h16, 16'h0, 8'h00));
    trap_is(1'b0);
    wr(OFF_PSW, 32'h08);
    wr(OFF_CMD, cm(5'h17, 16'h0, 8'h00));
    trap_is(1'b0);
    wr(OFF_CMD, cm(5'h16, 16'h0, 8'h00));
    trap_is(1'b1);
    rd(OFF_TRAP, q);
    chk(q, 32'h1);
    wr(OFF_TRAP, 32'h1);
    trap_is(1'b0);
    wr(OFF_PSW, 32'h04);
    wr(OFF_CMD, cm(5'h17, 16'h0, 8'h00));
    trap_is(1'b1);
    done("trap");
    give_verdict();
  end
endmodule
